/* common/zcel_pkg.sv */
// zero-cross event logic: constants shared by the design files
// assumes an 8-bit register port and a single clk_sys domain
package zcel_pkg;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] ZCEL_CTRL_OFS  = 8'h00;
    localparam logic [7:0] ZCEL_FLAG_OFS  = 8'h01;
    localparam logic [7:0] ZCEL_IEN_OFS   = 8'h02;
    localparam logic [7:0] ZCEL_GIEN_OFS  = 8'h03;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int ZCEL_EN_BIT    = 7;
    localparam int ZCEL_LEVEL_BIT = 5;
    localparam int ZCEL_POL_BIT   = 4;
    localparam int ZCEL_RISE_BIT  = 1;
    localparam int ZCEL_FALL_BIT  = 0;
    localparam int ZCEL_IRQF_BIT  = 4;
    localparam int ZCEL_IRQE_BIT  = 4;
    localparam int ZCEL_GRP_BIT   = 6;
    localparam int ZCEL_GLB_BIT   = 7;

    // -------------------------------------------------------------------
    // reset values and counts
    // -------------------------------------------------------------------
    localparam logic [7:0] ZCEL_CTRL_RST  = 8'h00;
    localparam logic       ZCEL_BIT_RST   = 1'b0;
    localparam logic [1:0] ZCEL_STRAP_CYC = 2'h2;

endpackage : zcel_pkg

/* rtl/zcel_sync.sv */
// zero-cross event logic: two-stage synchroniser for pin levels
// assumes inputs are asynchronous to clk_sys
module zcel_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // refused at elaboration: a zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : width_check
        $error("zcel_sync: WIDTH must be at least 1");
    end

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : zcel_sync

/* rtl/zcel_edge.sv */
// zero-cross event logic: rising and falling edge detector
// assumes level is already in the clk_sys domain
module zcel_edge (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);

    logic prev;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule : zcel_edge

/* rtl/zcel_top.sv */
// zero-cross event logic: control register, polarity, edge events, irq gating
// assumes an analog stage giving a sink-active level and a host register port
//
// Added by the designer: the strobed register port and the register offsets.
module zcel_top
    import zcel_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       sink_active,
    input  wire logic       por_disable_fuse,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            analog_enable,
    output logic            logic_level,
    output logic            irq_req
);

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    logic       detector_enable;
    logic       polarity_invert;
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic       crossing_irq_flag;
    logic       crossing_irq_enable;
    logic       peripheral_group_enable;
    logic       global_irq_enable;
    logic [1:0] pin_sync;
    logic       sink_sync;
    logic       fuse_sync;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic       strap_load;
    logic       next_level;
    logic       rise;
    logic       fall;
    logic       wr_ctrl;
    logic       wr_flag;
    logic       wr_ien;
    logic       wr_gien;
    logic       pol_change;
    logic       edge_set;
    logic       flag_set;
    logic [7:0] ctrl_view;
    logic [7:0] flag_view;
    logic [7:0] ien_view;
    logic [7:0] gien_view;
    logic [7:0] next_rdata;

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    zcel_sync #(
        .WIDTH    (2)
    ) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in ({por_disable_fuse, sink_active}),
        .sync_out (pin_sync)
    );

    assign sink_sync = pin_sync[0];
    assign fuse_sync = pin_sync[1];

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    assign wr_ctrl = reg_wr && (reg_addr == ZCEL_CTRL_OFS);
    assign wr_flag = reg_wr && (reg_addr == ZCEL_FLAG_OFS);
    assign wr_ien  = reg_wr && (reg_addr == ZCEL_IEN_OFS);
    assign wr_gien = reg_wr && (reg_addr == ZCEL_GIEN_OFS);

    // -------------------------------------------------------------------
    // fuse capture after reset release
    // -------------------------------------------------------------------
    // the fuse needs the synchroniser filled before it is believed
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            if (!strap_done) begin
                if (strap_cnt == ZCEL_STRAP_CYC) begin
                    strap_done <= 1'b1;
                end else begin
                    strap_cnt <= strap_cnt + 2'h1;
                end
            end
        end
    end

    assign strap_load = !strap_done && (strap_cnt == ZCEL_STRAP_CYC);

    // -------------------------------------------------------------------
    // control register
    // -------------------------------------------------------------------
    // fuse load beats a software write in the same cycle; hosts wait
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            detector_enable <= ZCEL_CTRL_RST[ZCEL_EN_BIT];
        end else if (strap_load) begin
            detector_enable <= ~fuse_sync;
        end else if (wr_ctrl) begin
            detector_enable <= reg_wdata[ZCEL_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            polarity_invert <= ZCEL_CTRL_RST[ZCEL_POL_BIT];
            rise_irq_enable <= ZCEL_CTRL_RST[ZCEL_RISE_BIT];
            fall_irq_enable <= ZCEL_CTRL_RST[ZCEL_FALL_BIT];
        end else if (wr_ctrl) begin
            polarity_invert <= reg_wdata[ZCEL_POL_BIT];
            rise_irq_enable <= reg_wdata[ZCEL_RISE_BIT];
            fall_irq_enable <= reg_wdata[ZCEL_FALL_BIT];
        end
    end

    assign analog_enable = detector_enable;

    // -------------------------------------------------------------------
    // enable registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crossing_irq_enable <= ZCEL_BIT_RST;
        end else if (wr_ien) begin
            crossing_irq_enable <= reg_wdata[ZCEL_IRQE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            peripheral_group_enable <= ZCEL_BIT_RST;
            global_irq_enable       <= ZCEL_BIT_RST;
        end else if (wr_gien) begin
            peripheral_group_enable <= reg_wdata[ZCEL_GRP_BIT];
            global_irq_enable       <= reg_wdata[ZCEL_GLB_BIT];
        end
    end

    // -------------------------------------------------------------------
    // logic level and edges
    // -------------------------------------------------------------------
    // an inactive analog stage neither sinks nor sources; read as zero
    assign next_level = detector_enable & (sink_sync ^ polarity_invert);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            logic_level <= 1'b0;
        end else begin
            logic_level <= next_level;
        end
    end

    // no sleep input on purpose: nothing here may stop in sleep
    zcel_edge u_edge (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .level   (logic_level),
        .rise    (rise),
        .fall    (fall)
    );

    // -------------------------------------------------------------------
    // crossing flag
    // -------------------------------------------------------------------
    assign edge_set   = (rise & rise_irq_enable) | (fall & fall_irq_enable);
    assign pol_change = wr_ctrl && (reg_wdata[ZCEL_POL_BIT] != polarity_invert);
    assign flag_set   = edge_set | pol_change;

    // set beats the clear so no crossing is lost
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crossing_irq_flag <= ZCEL_BIT_RST;
        end else if (flag_set) begin
            crossing_irq_flag <= 1'b1;
        end else if (wr_flag) begin
            crossing_irq_flag <= reg_wdata[ZCEL_IRQF_BIT];
        end
    end

    assign irq_req = crossing_irq_flag & crossing_irq_enable
                   & peripheral_group_enable & global_irq_enable;

    // -------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------
    always_comb begin
        ctrl_view                  = 8'h00;
        ctrl_view[ZCEL_EN_BIT]     = detector_enable;
        ctrl_view[ZCEL_LEVEL_BIT]  = logic_level;
        ctrl_view[ZCEL_POL_BIT]    = polarity_invert;
        ctrl_view[ZCEL_RISE_BIT]   = rise_irq_enable;
        ctrl_view[ZCEL_FALL_BIT]   = fall_irq_enable;
        flag_view                  = 8'h00;
        flag_view[ZCEL_IRQF_BIT]   = crossing_irq_flag;
        ien_view                   = 8'h00;
        ien_view[ZCEL_IRQE_BIT]    = crossing_irq_enable;
        gien_view                  = 8'h00;
        gien_view[ZCEL_GRP_BIT]    = peripheral_group_enable;
        gien_view[ZCEL_GLB_BIT]    = global_irq_enable;
    end

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ZCEL_CTRL_OFS: next_rdata = ctrl_view;
                ZCEL_FLAG_OFS: next_rdata = flag_view;
                ZCEL_IEN_OFS:  next_rdata = ien_view;
                ZCEL_GIEN_OFS: next_rdata = gien_view;
                default:       next_rdata = 8'h00;
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    sink_level_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (detector_enable && !polarity_invert && !wr_ctrl && !strap_load)
        |=> (logic_level == $past(sink_sync))
    ) else $error("level does not follow sink");

    inv_level_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (detector_enable && polarity_invert && !wr_ctrl && !strap_load)
        |=> (logic_level == !$past(sink_sync))
    ) else $error("inverted level does not follow source");

    rise_sets_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $rose(logic_level) && rise_irq_enable |=> crossing_irq_flag
    ) else $error("enabled rising edge did not set flag");

    fall_sets_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $fell(logic_level) && fall_irq_enable |=> crossing_irq_flag
    ) else $error("enabled falling edge did not set flag");

    rise_gated_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $rose(logic_level) && !rise_irq_enable && !crossing_irq_flag
            && !reg_wr
        |=> !crossing_irq_flag
    ) else $error("disabled rising edge set flag");

    fall_gated_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $fell(logic_level) && !fall_irq_enable && !crossing_irq_flag
            && !reg_wr
        |=> !crossing_irq_flag
    ) else $error("disabled falling edge set flag");

    irq_gate_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        irq_req |-> (crossing_irq_flag && crossing_irq_enable
                     && peripheral_group_enable && global_irq_enable)
    ) else $error("irq request without all enables");

    irq_follow_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $rose(crossing_irq_flag) && crossing_irq_enable
            && peripheral_group_enable && global_irq_enable && !reg_wr
        |-> irq_req
    ) else $error("enabled flag not forwarded");

    pol_event_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr_ctrl && (reg_wdata[ZCEL_POL_BIT] != polarity_invert)
        |=> crossing_irq_flag && $changed(polarity_invert)
    ) else $error("polarity change gave no event");

    flag_hold_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        crossing_irq_flag && !wr_flag |=> crossing_irq_flag
    ) else $error("flag cleared without software");

    set_wins_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        edge_set && wr_flag && !reg_wdata[ZCEL_IRQF_BIT] |=> crossing_irq_flag
    ) else $error("clear beat a coincident edge");

    fuse_load_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        strap_load |=> (detector_enable == !$past(fuse_sync)) && strap_done
    ) else $error("fuse not applied to enable");

    fuse_hold_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        strap_done && !detector_enable && !wr_ctrl |=> !detector_enable
    ) else $error("detector enabled without software");

    read_data_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        reg_rd && (reg_addr == ZCEL_FLAG_OFS)
        |=> reg_rdata[ZCEL_IRQF_BIT] == $past(crossing_irq_flag)
    ) else $error("flag read returned wrong data");

    read_idle_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !reg_rd |=> (reg_rdata == 8'h00)
    ) else $error("read data outside read cycle");

    clear_works_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr_flag && !reg_wdata[ZCEL_IRQF_BIT] && !flag_set |=> !crossing_irq_flag
    ) else $error("software clear did not clear flag");

    level_off_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !detector_enable |=> !logic_level
    ) else $error("level shown while detector off");

    rise_seen_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $rose(logic_level) |-> rise && !fall
    ) else $error("rising level missed by detector");

    fall_seen_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $fell(logic_level) |-> fall && !rise
    ) else $error("falling level missed by detector");

    sync_depth_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        strap_done |-> (sink_sync == $past(sink_active, 2))
    ) else $error("sink indication not two flops deep");

endmodule : zcel_top

/* sim/zcel_analog_model.sv */
// zero-cross event logic: behavioural model of the analog current stage
// assumes the bench steers the wanted sink state; one clk_sys domain
module zcel_analog_model #(
    parameter int LAG = 1
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic analog_enable,
    input  wire logic want_sink,
    output logic      sink_active
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] pipe;

    // -------------------------------------------------------------------
    // current stage
    // -------------------------------------------------------------------
    // high means sinking; the lag lets the stage answer slowly
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pipe <= 8'h00;
        end else begin
            pipe <= {pipe[6:0], want_sink};
        end
    end

    // stage switched off neither sinks nor sources, so no sink shown
    assign sink_active = analog_enable & pipe[LAG-1];

endmodule : zcel_analog_model

/* sim/zcel_top_tb.sv */
// zero-cross event logic: self-checking bench for zcel_top
// assumes the analog model in zcel_analog_model and a 250 MHz clk_sys
module zcel_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import zcel_pkg::*;

    logic       clk_sys;
    logic       resetn;
    logic       sink_active;
    logic       por_disable_fuse;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       analog_enable;
    logic       logic_level;
    logic       irq_req;
    logic       want_sink;
    int         n_fail;
    int         total_checks;
    int         cycles;

    zcel_top zcel_top_i (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .sink_active      (sink_active),
        .por_disable_fuse (por_disable_fuse),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .analog_enable    (analog_enable),
        .logic_level      (logic_level),
        .irq_req          (irq_req)
    );

    zcel_analog_model #(.LAG(1)) zcel_analog_model_i (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .analog_enable (analog_enable),
        .want_sink     (want_sink),
        .sink_active   (sink_active)
    );

    // -------------------------------------------------------------------
    // clock, timeout and shared tasks
    // -------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // whole run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // strobe held one cycle, then a gap edge so no signal is driven twice
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clk_sys);
    endtask : rd

    task automatic do_reset(input logic fuse);
        resetn           <= 1'b0;
        por_disable_fuse <= fuse;
        want_sink        <= 1'b0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : do_reset

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset_values();
        rd(ZCEL_CTRL_OFS, 8'h80);
        chk({7'h00, analog_enable}, 8'h01);
        rd(ZCEL_FLAG_OFS, 8'h00);
        rd(ZCEL_IEN_OFS, 8'h00);
        rd(ZCEL_GIEN_OFS, 8'h00);
        rd(8'h10, 8'h00);
    endtask : t_reset_values

    task automatic t_edge(input logic rise_en, input logic fall_en, input logic lvl, input logic [7:0] exp_flag);
        wr(ZCEL_CTRL_OFS, {6'h20, rise_en, fall_en});
        wr(ZCEL_FLAG_OFS, 8'h00);
        want_sink <= lvl;
        repeat (8) @(posedge clk_sys);
        rd(ZCEL_FLAG_OFS, exp_flag);
        rd(ZCEL_CTRL_OFS, {2'h2, lvl, 3'h0, rise_en, fall_en});
    endtask : t_edge

    task automatic t_polarity();
        wr(ZCEL_FLAG_OFS, 8'h00);
        wr(ZCEL_CTRL_OFS, 8'h90);
        rd(ZCEL_FLAG_OFS, 8'h10);
        repeat (4) @(posedge clk_sys);
        chk({7'h00, logic_level}, 8'h01);
        rd(ZCEL_CTRL_OFS, 8'hB0);
        wr(ZCEL_CTRL_OFS, 8'h00);
        wr(ZCEL_FLAG_OFS, 8'h00);
        wr(ZCEL_CTRL_OFS, 8'h10);
        rd(ZCEL_FLAG_OFS, 8'h10);
        chk({6'h00, analog_enable, logic_level}, 8'h00);
    endtask : t_polarity

    task automatic t_irq_gate();
        for (int i = 0; i < 8; i++) begin
            wr(ZCEL_IEN_OFS, {3'h0, i[0], 4'h0});
            wr(ZCEL_GIEN_OFS, {i[2], i[1], 6'h00});
            chk({7'h00, irq_req}, {7'h00, (i == 7)});
        end
        repeat (20) @(posedge clk_sys);
        rd(ZCEL_FLAG_OFS, 8'h10);
        wr(ZCEL_FLAG_OFS, 8'h00);
        chk({7'h00, irq_req}, 8'h00);
    endtask : t_irq_gate

    // clear strobe lands on the very edge that sets the flag
    task automatic t_clear_race();
        wr(ZCEL_CTRL_OFS, 8'h82);
        wr(ZCEL_FLAG_OFS, 8'h00);
        rd(ZCEL_FLAG_OFS, 8'h00);
        want_sink <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h00, logic_level}, 8'h00);
        @(posedge clk_sys);
        wr(ZCEL_FLAG_OFS, 8'h00);
        rd(ZCEL_FLAG_OFS, 8'h10);
        chk({7'h00, logic_level}, 8'h01);
    endtask : t_clear_race

    task automatic t_fuse_set();
        do_reset(1'b1);
        rd(ZCEL_CTRL_OFS, 8'h00);
        want_sink <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk({6'h00, analog_enable, logic_level}, 8'h00);
        wr(ZCEL_CTRL_OFS, 8'h80);
        repeat (8) @(posedge clk_sys);
        chk({6'h00, analog_enable, logic_level}, 8'h03);
    endtask : t_fuse_set

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        n_fail           = 0;
        total_checks     = 0;
        cycles           = 0;
        resetn           = 1'b0;
        por_disable_fuse = 1'b0;
        want_sink        = 1'b0;
        reg_addr         = 8'h00;
        reg_wdata        = 8'h00;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        @(posedge clk_sys);
        do_reset(1'b0);
        t_reset_values();
        t_edge(1'b1, 1'b0, 1'b1, 8'h10);
        t_edge(1'b1, 1'b0, 1'b0, 8'h00);
        t_edge(1'b0, 1'b1, 1'b1, 8'h00);
        t_edge(1'b0, 1'b1, 1'b0, 8'h10);
        t_polarity();
        t_irq_gate();
        wr(ZCEL_CTRL_OFS, 8'h80);
        repeat (6) @(posedge clk_sys);
        t_clear_race();
        t_fuse_set();
        summarize();
    end

endmodule : zcel_top_tb
